// File: design/tx_codec_pkg.sv
// Constants, types and code tables shared by the transmit parity check and encoder select
package tx_codec_pkg;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		LVL_LOW  = 2'b00,
		LVL_MID  = 2'b01,
		LVL_HIGH = 2'b10
	} level_t;

	typedef enum logic [1:0] {
		K_DATA    = 2'b00,
		K_SPECIAL = 2'b01,
		K_FILL    = 2'b10,
		K_WSYNC   = 2'b11
	} kind_t;

	typedef enum logic [1:0] {
		SEL_HOLD = 2'b00,
		SEL_ENC  = 2'b01,
		SEL_VIOL = 2'b10,
		SEL_RAW  = 2'b11
	} sel_t;

	// ****************************************************************
	// Widths and field positions of a queued character word
	// ****************************************************************
	localparam int CHAR_W     = 8;
	localparam int CTL_W      = 2;
	localparam int SYM_W      = 10;
	localparam int WORD_W     = 12;
	localparam int F_BYTE_LSB = 0;
	localparam int F_CTL_LSB  = 8;
	localparam int F_PAR_BIT  = 10;
	localparam int F_SEL_BIT  = 11;
	localparam int FIFO_DEPTH = 8;

	// ****************************************************************
	// Sequence counts, reset values and fixed symbols
	// ****************************************************************
	localparam logic [3:0]       WSYNC_REMAIN = 4'hF;
	localparam logic [CTL_W-1:0] CTL_NONE     = 2'h0;
	localparam logic [SYM_W-1:0] SYM_RESET    = 10'h000;
	localparam logic             RD_RESET     = 1'b0;
	// Violation symbols written with bit a on the left
	localparam logic [SYM_W-1:0] VIOL_POS_STR = 10'h278;
	localparam logic [SYM_W-1:0] VIOL_NEG_STR = 10'h187;
	localparam logic [7:0]       COMMA_BYTE   = 8'hBC;
	localparam logic [4:0]       K_X28        = 5'h1C;
	localparam logic [3:0]       EXT_K_COUNT  = 4'hC;

	// ****************************************************************
	// 8B/10B sub-block tables, negative running disparity forms
	// ****************************************************************
	localparam logic [5:0] TBL6 [32] = '{
		6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
		6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
		6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
	localparam logic [5:0] K28_6B   = 6'h0F;
	localparam logic [3:0] TBL4 [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
	localparam logic [3:0] TBL4K[8] = '{4'hB, 4'h6, 4'hA, 4'hC, 4'hD, 4'h5, 4'h9, 4'h7};
	localparam logic [3:0] ALT7_4B  = 4'h7;
	// Extended special table: index to full control code byte
	localparam logic [7:0] EXT_K [12] = '{
		8'h1C, 8'h3C, 8'h5C, 8'h7C, 8'h9C, 8'hBC, 8'hDC, 8'hFC,
		8'hF7, 8'hFB, 8'hFD, 8'hFE};

endpackage

// File: design/char_stream_if.sv
// Valid and ready character stream between the codec and its input FIFO
interface char_stream_if #(
	parameter int WIDTH = 12
);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;

	modport source (output valid, output data, input ready);
	modport sink   (input valid, input data, output ready);
endinterface

// File: design/char_fifo.sv
// Character FIFO with registered head word and registered full and empty flags
module char_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic     ref_clk_in,
	input  wire logic     resetn_in,
	// Filling and draining sides
	char_stream_if.sink   fill,
	char_stream_if.source drain
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr, next_wr_ptr;
	logic [AW-1:0]    rd_ptr, next_rd_ptr;
	logic [AW:0]      count, next_count;
	logic             full, next_full;
	logic             empty, next_empty;
	logic             room, next_room;
	logic [WIDTH-1:0] head, next_head;
	logic             do_wr;
	logic             do_rd;

	// Ready comes straight from its own register, not from an inverter
	assign fill.ready  = room;
	assign drain.valid = ~empty;
	assign drain.data  = head;

	// ****************************************************************
	// Pointer, level and head word update
	// ****************************************************************
	always_comb begin
		do_wr       = fill.valid & ~full;
		do_rd       = drain.ready & ~empty;
		next_wr_ptr = do_wr ? AW'(wr_ptr + 1'b1) : wr_ptr;
		next_rd_ptr = do_rd ? AW'(rd_ptr + 1'b1) : rd_ptr;
		next_count  = (AW+1)'(count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd});
		next_full   = (next_count == (AW+1)'(DEPTH));
		next_empty  = (next_count == '0);
		next_room   = ~next_full;
		// A word being written into the slot about to become head bypasses the array
		if (do_wr && (wr_ptr == next_rd_ptr)) begin
			next_head = fill.data;
		end else begin
			next_head = mem[next_rd_ptr];
		end
	end

	// Registers of the FIFO state
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
			full   <= 1'b0;
			empty  <= 1'b1;
			room   <= 1'b1;
			head   <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
			full   <= next_full;
			empty  <= next_empty;
			room   <= next_room;
			head   <= next_head;
		end
	end

	// Storage array write port
	always_ff @(posedge ref_clk_in) begin
		if (do_wr) begin
			mem[wr_ptr] <= fill.data;
		end
	end

endmodule

// File: design/tx_parity_check_and_encoder_select.sv
// Transmit channel parity check, 8B/10B encoder and output character selection
module tx_parity_check_and_encoder_select (
	// Clock and reset
	input  wire logic                               ref_clk_in,
	input  wire logic                               resetn_in,
	// Host character input
	input  wire logic                               tx_char_valid_in,
	input  wire logic [tx_codec_pkg::CHAR_W-1:0]    tx_char_byte_in,
	input  wire logic [tx_codec_pkg::CTL_W-1:0]     tx_char_control_bits_in,
	input  wire logic                               tx_odd_parity_bit_in,
	input  wire logic                               special_char_select_in,
	output logic                                    tx_in_ready_out,
	// Static configuration
	input  wire tx_codec_pkg::level_t               parity_check_select_in,
	input  wire tx_codec_pkg::level_t               tx_mode_select_hi_in,
	input  wire tx_codec_pkg::level_t               tx_mode_select_lo_in,
	input  wire logic                               special_table_select_in,
	// Channel status and self-test source
	input  wire logic                               pab_error_in,
	input  wire logic                               bist_active_in,
	input  wire logic [tx_codec_pkg::SYM_W-1:0]     bist_char_in,
	// Transmit shifter side
	input  wire logic                               shifter_ready_in,
	output logic      [tx_codec_pkg::SYM_W-1:0]     tx_char_out,
	output logic                                    tx_channel_error_flag_out,
	output logic                                    running_disparity_out
);
	import tx_codec_pkg::*;

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Bit order turn: symbol strings hold bit a on the left, the shifter wants it in bit 0
	function automatic logic [SYM_W-1:0] rev10(input logic [SYM_W-1:0] s);
		logic [SYM_W-1:0] r;
		r = '0;
		for (int i = 0; i < SYM_W; i++) begin
			r[i] = s[SYM_W-1-i];
		end
		return r;
	endfunction

	// 8B/10B encode; returns the new running disparity above the symbol string
	function automatic logic [SYM_W:0] enc8b10b(input logic [7:0] b, input logic k, input logic rd);
		logic [4:0] x;
		logic [2:0] y;
		logic [5:0] s6;
		logic [3:0] s4;
		logic       k28;
		logic       u6;
		logic       u4;
		logic       rd6;
		logic       alt;
		x   = b[4:0];
		y   = b[7:5];
		k28 = k & (x == K_X28);
		s6  = k28 ? K28_6B : TBL6[x];
		u6  = ($countones(s6) != 3);
		// D.07 is balanced but still takes its complement at positive disparity
		if (rd && (u6 || (x == 5'h07))) begin
			s6 = ~s6;
		end
		rd6 = rd ^ u6;
		alt = (y == 3'h7) && (k || (!rd6 && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
			(rd6 && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
		s4  = k28 ? TBL4K[y] : (alt ? ALT7_4B : TBL4[y]);
		u4  = ($countones(s4) != 2);
		if (rd6 && (u4 || (y == 3'h3) || k28)) begin
			s4 = ~s4;
		end
		return {rd6 ^ u4, s6, s4};
	endfunction

	// Parity failure over the bits that the select level puts under check
	function automatic logic parity_err(input logic [WORD_W-1:0] w, input level_t psel, input logic enc);
		logic [CHAR_W-1:0] byt;
		logic [CTL_W-1:0]  ctl;
		logic              p;
		byt = w[F_BYTE_LSB +: CHAR_W];
		ctl = w[F_CTL_LSB +: CTL_W];
		p   = w[F_PAR_BIT];
		case (psel)
			LVL_MID:  parity_err = enc ? ~(^{byt, p}) : ~(^{ctl, byt, p});
			LVL_HIGH: parity_err = ~(^{ctl, byt, p});
			default:  parity_err = 1'b0;
		endcase
	endfunction

	// Character kind from the lower mode level, special select and control bits
	function automatic kind_t classify(input level_t lo, input logic scs, input logic [CTL_W-1:0] ctl);
		if (!ctl[0]) begin
			classify = K_DATA;
		end else begin
			case (lo)
				LVL_LOW:  classify = ctl[1] ? K_WSYNC : (scs ? K_SPECIAL : K_FILL);
				LVL_MID:  classify = scs ? K_WSYNC : (ctl[1] ? K_SPECIAL : K_FILL);
				default:  classify = ctl[1] ? K_WSYNC : K_SPECIAL;
			endcase
		end
	endfunction

	// ****************************************************************
	// Input FIFO
	// ****************************************************************
	char_stream_if #(.WIDTH(WORD_W)) fill_if ();
	char_stream_if #(.WIDTH(WORD_W)) drain_if ();

	// Parity bit is queued with its character and the select line it travels with
	assign fill_if.valid = tx_char_valid_in;
	assign fill_if.data  = {special_char_select_in, tx_odd_parity_bit_in, tx_char_control_bits_in,
		tx_char_byte_in};
	assign tx_in_ready_out = fill_if.ready;

	char_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.ref_clk_in (ref_clk_in),
		.resetn_in  (resetn_in),
		.fill       (fill_if),
		.drain      (drain_if)
	);

	// ****************************************************************
	// Character selection state
	// ****************************************************************
	logic [SYM_W-1:0]  sym, next_sym;
	logic              rd, next_rd;
	logic              flag, next_flag;
	logic [3:0]        ws_left, next_ws_left;
	logic [CHAR_W-1:0] head_byte;
	logic [CTL_W-1:0]  head_ctl;
	logic              enc_on;
	logic              atomic;
	logic              seq_busy;
	logic              perr;
	logic              head_take;
	kind_t             kind;
	sel_t              sel;
	logic [7:0]        enc_byte;
	logic              enc_k;
	logic [SYM_W-1:0]  raw_word;
	logic [SYM_W:0]    enc_res;
	logic [3:0]        spec_idx;

	assign head_byte = drain_if.data[F_BYTE_LSB +: CHAR_W];
	assign head_ctl  = drain_if.data[F_CTL_LSB +: CTL_W];
	assign enc_on    = (tx_mode_select_hi_in != LVL_LOW);
	assign atomic    = (tx_mode_select_hi_in == LVL_MID);
	assign seq_busy  = (ws_left != 4'h0);
	assign spec_idx  = head_byte[3:0];

	// Head character checked in the cycle it is presented to the encoder
	assign perr = parity_err(drain_if.data, parity_check_select_in, enc_on);
	// Special select is ignored when the lower mode level is high
	assign kind = classify(tx_mode_select_lo_in, drain_if.data[F_SEL_BIT] &
		(tx_mode_select_lo_in != LVL_HIGH), head_ctl);

	// Decide which source feeds the shifter this character cycle
	always_comb begin
		sel          = SEL_HOLD;
		enc_byte     = COMMA_BYTE;
		enc_k        = 1'b1;
		raw_word     = bist_char_in;
		next_flag    = flag;
		next_ws_left = ws_left;
		head_take    = 1'b0;
		drain_if.ready = 1'b0;
		if (shifter_ready_in) begin
			next_flag = 1'b0;
			sel       = SEL_ENC;
			if (pab_error_in) begin
				// Buffer fault: discard input, send violation while it lasts
				sel            = SEL_VIOL;
				next_flag      = 1'b1;
				next_ws_left   = 4'h0;
				drain_if.ready = drain_if.valid;
			end else if (bist_active_in) begin
				sel          = SEL_RAW;
				next_ws_left = 4'h0;
			end else if (seq_busy && atomic) begin
				// Queue is held while the atomic sequence runs out
				next_ws_left = ws_left - 4'h1;
			end else if (drain_if.valid) begin
				drain_if.ready = 1'b1;
				head_take      = 1'b1;
				if (seq_busy && (head_ctl == CTL_NONE) && !perr) begin
					next_ws_left = ws_left - 4'h1;
				end else begin
					next_ws_left = 4'h0;
					if (perr) begin
						sel       = SEL_VIOL;
						next_flag = 1'b1;
					end else if (!enc_on) begin
						sel      = SEL_RAW;
						raw_word = {head_ctl, head_byte};
					end else begin
						unique case (kind)
							K_DATA: begin
								enc_byte = head_byte;
								enc_k    = 1'b0;
							end
							K_SPECIAL: begin
								// Two separate code tables, unmapped codes become violations
								if (special_table_select_in) begin
									enc_byte = head_byte;
									if ((head_byte[4:0] != K_X28) && !((head_byte[7:5] == 3'h7) &&
										(head_byte[4:0] inside {5'h17, 5'h1B, 5'h1D, 5'h1E}))) begin
										sel = SEL_VIOL;
									end
								end else if (spec_idx < EXT_K_COUNT) begin
									enc_byte = EXT_K[spec_idx];
								end else begin
									sel = SEL_VIOL;
								end
							end
							K_FILL: begin
								enc_byte = COMMA_BYTE;
							end
							K_WSYNC: begin
								enc_byte     = COMMA_BYTE;
								next_ws_left = WSYNC_REMAIN;
							end
						endcase
					end
				end
			end
		end
	end

	// Symbol and disparity from the chosen source
	always_comb begin
		enc_res  = enc8b10b(enc_byte, enc_k, rd);
		next_sym = sym;
		next_rd  = rd;
		unique case (sel)
			SEL_HOLD: begin
				next_sym = sym;
			end
			SEL_ENC: begin
				next_sym = rev10(enc_res[SYM_W-1:0]);
				next_rd  = enc_res[SYM_W];
			end
			SEL_VIOL: begin
				next_sym = rev10((enc_on && !rd) ? VIOL_NEG_STR : VIOL_POS_STR);
			end
			SEL_RAW: begin
				next_sym = raw_word;
			end
		endcase
	end

	// Output registers of the character stage
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sym     <= SYM_RESET;
			rd      <= RD_RESET;
			flag    <= 1'b0;
			ws_left <= 4'h0;
		end else begin
			sym     <= next_sym;
			rd      <= next_rd;
			flag    <= next_flag;
			ws_left <= next_ws_left;
		end
	end

	assign tx_char_out               = sym;
	assign tx_channel_error_flag_out = flag;
	assign running_disparity_out     = rd;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!resetn_in);

	chk_bypass_viol: assert property (
		head_take && perr && !enc_on |=> (tx_char_out == rev10(VIOL_POS_STR)) && tx_channel_error_flag_out)
		else $error("bypass parity error did not send positive violation");

	chk_enc_viol: assert property (
		head_take && perr && enc_on && !rd |=> (tx_char_out == rev10(VIOL_NEG_STR)) && tx_channel_error_flag_out)
		else $error("encoded parity error did not send violation");

	chk_parity_off: assert property (
		drain_if.valid && (parity_check_select_in == LVL_LOW) |-> !perr)
		else $error("parity flagged while checking disabled");

	chk_mid_enc_bits: assert property (
		drain_if.valid && (parity_check_select_in == LVL_MID) && enc_on |-> perr == !(^drain_if.data[F_PAR_BIT:0]
		^ (^head_ctl)))
		else $error("mid level parity covers wrong bits");

	chk_pab_viol: assert property (
		shifter_ready_in && pab_error_in |=> tx_channel_error_flag_out && (tx_char_out == rev10(VIOL_POS_STR) ||
		tx_char_out == rev10(VIOL_NEG_STR)))
		else $error("buffer fault did not force violation");

	chk_raw_pass: assert property (
		head_take && !perr && !enc_on && !seq_busy |=> tx_char_out == $past(drain_if.data[SYM_W-1:0]) &&
		!tx_channel_error_flag_out)
		else $error("bypass character altered");

	chk_atomic_hold: assert property (
		seq_busy && atomic && shifter_ready_in && !pab_error_in && !bist_active_in |-> !drain_if.ready
		##1 ws_left == $past(ws_left) - 4'h1)
		else $error("atomic sequence consumed input or skipped a count");

	chk_wsync_start: assert property (
		head_take && !seq_busy && !perr && enc_on && kind == K_WSYNC |=> ws_left == WSYNC_REMAIN)
		else $error("word sync did not load fifteen remaining");

	chk_interrupt_end: assert property (
		head_take && seq_busy && !atomic && (head_ctl != CTL_NONE) |=>
		ws_left == (($past(kind) == K_WSYNC && !$past(perr)) ? WSYNC_REMAIN : 4'h0))
		else $error("interruptible sequence not terminated");

endmodule

// File: verif/host_char_source.sv
// Host logic model that offers parity-tagged characters to one transmit channel
module host_char_source (
	// Clock and flow control
	input  wire logic  ref_clk_in,
	input  wire logic  ready_in,
	// Character word offered to the channel
	output logic       valid_out,
	output logic [7:0] byte_out,
	output logic [1:0] ctl_out,
	output logic       parity_out,
	output logic       select_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// Quiet lines at time zero
	initial begin
		valid_out  = 1'b0;
		byte_out   = 8'h00;
		ctl_out    = 2'h0;
		parity_out = 1'b0;
		select_out = 1'b0;
	end

	// Offer one word at an edge and hold it until the channel takes it
	task automatic send(input logic [7:0] b, input logic [1:0] c, input logic p, input logic s);
		valid_out  <= 1'b1;
		byte_out   <= b;
		ctl_out    <= c;
		parity_out <= p;
		select_out <= s;
		@(posedge ref_clk_in);
		while (ready_in !== 1'b1) begin
			@(posedge ref_clk_in);
		end
	endtask

	// Drop the request and scramble byte, control and parity so no stale word lingers; the select line keeps its value
	task automatic release_bus();
		valid_out  <= 1'b0;
		byte_out   <= ~byte_out;
		ctl_out    <= ~ctl_out;
		parity_out <= ~parity_out;
		@(posedge ref_clk_in);
	endtask
endmodule

// File: verif/tb_tx_parity_check_and_encoder_select.sv
// Self-checking bench for the transmit parity check and encoder select
`define CHK(act, exp) begin n_checks++; if ((act) !== (exp)) begin error_cnt++; $display("[ERR] %0t got %h want %h", $time, act, exp); end end
module tb_tx_parity_check_and_encoder_select;
	import tx_codec_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// Signals, clock and timeout
	// ****************************************************************
	localparam logic [9:0] K_NEG = 10'h17C;
	localparam logic [9:0] K_POS = 10'h283;
	localparam logic [9:0] D00   = 10'h0B9;
	logic       ref_clk_in = 1'b0;
	logic       resetn_in;
	logic       shifter_ready;
	logic       pab_error;
	logic       bist_active;
	logic       tbl_sel;
	logic [9:0] bist_char;
	level_t     par_sel;
	level_t     mode_hi;
	level_t     mode_lo;
	logic       valid;
	logic [7:0] byte_v;
	logic [1:0] ctl;
	logic       par;
	logic       sel;
	logic       ready;
	logic [9:0] sym;
	logic       flag;
	logic       disp;
	int         error_cnt = 0;
	int         n_checks = 0;
	int         cycles = 0;

	always #2.5 ref_clk_in = ~ref_clk_in;

	// Cut a hang short
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 4000) begin
			error_cnt++;
			wrap_up();
		end
	end

	host_char_source host (.ref_clk_in(ref_clk_in), .ready_in(ready), .valid_out(valid), .byte_out(byte_v),
		.ctl_out(ctl), .parity_out(par), .select_out(sel));

	tx_parity_check_and_encoder_select DUT (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
		.tx_char_valid_in(valid), .tx_char_byte_in(byte_v), .tx_char_control_bits_in(ctl),
		.tx_odd_parity_bit_in(par), .special_char_select_in(sel), .tx_in_ready_out(ready),
		.parity_check_select_in(par_sel), .tx_mode_select_hi_in(mode_hi), .tx_mode_select_lo_in(mode_lo),
		.special_table_select_in(tbl_sel), .pab_error_in(pab_error), .bist_active_in(bist_active),
		.bist_char_in(bist_char), .shifter_ready_in(shifter_ready), .tx_char_out(sym),
		.tx_channel_error_flag_out(flag), .running_disparity_out(disp));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Symbols are listed a..j from the left; the output carries a in bit 0
	function automatic logic [9:0] rev(input logic [9:0] s);
		for (int i = 0; i < 10; i++) begin
			rev[i] = s[9 - i];
		end
	endfunction

	// Reset with a new static configuration, then check reset outputs
	task automatic start(input level_t p, input level_t h, input level_t l);
		@(posedge ref_clk_in);
		resetn_in <= 1'b0;
		par_sel   <= p;
		mode_hi   <= h;
		mode_lo   <= l;
		repeat (2) @(posedge ref_clk_in);
		resetn_in <= 1'b1;
		@(posedge ref_clk_in);
		`CHK(sym, SYM_RESET)
		`CHK(flag, 1'b0)
		`CHK(disp, RD_RESET)
		`CHK(ready, 1'b1)
	endtask

	// Let the shifter take exactly one symbol and judge it
	task automatic step(input logic [9:0] exp, input logic ef);
		@(posedge ref_clk_in);
		shifter_ready <= 1'b1;
		@(posedge ref_clk_in);
		shifter_ready <= 1'b0;
		#1;
		`CHK(sym, exp)
		`CHK(flag, ef)
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_bypass();
		start(LVL_MID, LVL_LOW, LVL_LOW);
		host.send(8'h35, 2'b10, 1'b0, 1'b0);
		host.send(8'h35, 2'b10, 1'b1, 1'b0);
		host.send(8'h35, 2'b00, 1'b1, 1'b0);
		host.release_bus();
		step(10'h235, 1'b0);
		step(rev(VIOL_POS_STR), 1'b1);
		step(10'h035, 1'b0);
		start(LVL_LOW, LVL_LOW, LVL_LOW);
		host.send(8'h35, 2'b10, 1'b1, 1'b0);
		host.release_bus();
		step(10'h235, 1'b0);
		$display("bypass and parity off done");
	endtask

	task automatic t_encoded();
		start(LVL_MID, LVL_MID, LVL_HIGH);
		host.send(8'h00, 2'b10, 1'b1, 1'b0);
		host.send(8'h00, 2'b00, 1'b0, 1'b0);
		host.send(8'h05, 2'b01, 1'b1, 1'b0);
		host.release_bus();
		step(D00, 1'b0);
		step(rev(VIOL_NEG_STR), 1'b1);
		step(K_NEG, 1'b0);
		start(LVL_HIGH, LVL_MID, LVL_HIGH);
		host.send(8'h00, 2'b10, 1'b1, 1'b0);
		host.send(8'h00, 2'b00, 1'b1, 1'b0);
		host.release_bus();
		step(rev(VIOL_NEG_STR), 1'b1);
		step(D00, 1'b0);
		$display("encoded parity done");
	endtask

	task automatic t_word_sync();
		start(LVL_MID, LVL_MID, LVL_LOW);
		host.send(8'h00, 2'b11, 1'b1, 1'b0);
		host.send(8'h00, 2'b00, 1'b1, 1'b0);
		host.release_bus();
		for (int i = 0; i < 16; i++) begin
			step(i % 2 ? K_POS : K_NEG, 1'b0);
		end
		step(D00, 1'b0);
		`CHK(disp, 1'b0)
		start(LVL_MID, LVL_HIGH, LVL_HIGH);
		host.send(8'h00, 2'b11, 1'b1, 1'b0);
		host.send(8'h00, 2'b00, 1'b1, 1'b0);
		host.send(8'h00, 2'b10, 1'b1, 1'b0);
		host.send(8'h00, 2'b11, 1'b1, 1'b0);
		host.send(8'h00, 2'b00, 1'b0, 1'b0);
		host.release_bus();
		step(K_NEG, 1'b0);
		step(K_POS, 1'b0);
		step(D00, 1'b0);
		step(K_NEG, 1'b0);
		step(rev(VIOL_POS_STR), 1'b1);
		$display("word sync done");
	endtask

	task automatic t_fault_bist();
		start(LVL_MID, LVL_MID, LVL_HIGH);
		step(K_NEG, 1'b0);
		@(posedge ref_clk_in);
		pab_error <= 1'b1;
		step(rev(VIOL_POS_STR), 1'b1);
		step(rev(VIOL_POS_STR), 1'b1);
		`CHK(disp, 1'b1)
		@(posedge ref_clk_in);
		pab_error   <= 1'b0;
		bist_active <= 1'b1;
		bist_char   <= 10'h2A5;
		step(10'h2A5, 1'b0);
		@(posedge ref_clk_in);
		bist_active <= 1'b0;
		$display("fault and self-test done");
	endtask

	task automatic t_fill();
		start(LVL_LOW, LVL_LOW, LVL_LOW);
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			host.send(8'(i), 2'b00, 1'b0, 1'b0);
		end
		host.release_bus();
		`CHK(ready, 1'b0)
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			step(10'(i), 1'b0);
		end
		`CHK(ready, 1'b1)
		$display("buffer fill done");
	endtask

	// Both special code tables, unmapped codes and the lower mode levels MID and LOW
	task automatic t_tables();
		start(LVL_LOW, LVL_HIGH, LVL_MID);
		host.send(8'h0C, 2'b11, 1'b0, 1'b0);
		host.send(8'h08, 2'b11, 1'b0, 1'b0);
		host.send(8'h00, 2'b01, 1'b0, 1'b0);
		host.release_bus();
		step(rev(VIOL_NEG_STR), 1'b0);
		step(10'h057, 1'b0);
		step(K_NEG, 1'b0);
		`CHK(disp, 1'b1)
		@(posedge ref_clk_in);
		tbl_sel <= 1'b1;
		start(LVL_LOW, LVL_MID, LVL_LOW);
		host.send(8'hBC, 2'b01, 1'b0, 1'b1);
		host.send(8'h35, 2'b01, 1'b0, 1'b1);
		host.release_bus();
		step(K_NEG, 1'b0);
		step(rev(VIOL_POS_STR), 1'b0);
		`CHK(disp, 1'b1)
		$display("special tables done");
	endtask

	// ****************************************************************
	// Main sequence and verdict
	// ****************************************************************
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		resetn_in     = 1'b0;
		shifter_ready = 1'b0;
		pab_error     = 1'b0;
		bist_active   = 1'b0;
		tbl_sel       = 1'b0;
		bist_char     = 10'h000;
		par_sel       = LVL_MID;
		mode_hi       = LVL_MID;
		mode_lo       = LVL_HIGH;
		repeat (20) @(posedge ref_clk_in);
		t_bypass();
		t_encoded();
		t_word_sync();
		t_fault_bist();
		t_fill();
		t_tables();
		wrap_up();
	end
endmodule
